//--- src/tcc_pkg.sv
// tcc_pkg: register map, field positions and reset values of the timer
// capture/compare control block.
// assumes an avalon-mm slave with 32-bit data and byte offsets, not all word-aligned (0x0E, 0x0F).
package tcc_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CNT       = 8'h04;
	localparam logic [7:0] OFS_SCR1      = 8'h08;
	localparam logic [7:0] OFS_TOV       = 8'h0C;
	localparam logic [7:0] OFS_CFLAG     = 8'h0E;
	localparam logic [7:0] OFS_OFLAG     = 8'h0F;
	localparam logic [7:0] OFS_ACT       = 8'h14;
	localparam logic [7:0] OFS_EDGE      = 8'h18;
	localparam logic [7:0] OFS_IEN       = 8'h1C;
	localparam logic [7:0] OFS_IOS       = 8'h20;
	localparam logic [7:0] OFS_FORCE     = 8'h24;
	localparam logic [7:0] OFS_OVR_MASK  = 8'h28;
	localparam logic [7:0] OFS_OVR_DATA  = 8'h2C;
	localparam logic [7:0] OFS_CH_BASE   = 8'h40;
	localparam logic [7:0] OFS_CH_LAST   = 8'h5C;
	localparam logic [7:0] OFS_ACC       = 8'h60;
	localparam logic [7:0] OFS_AFLAG     = 8'h64;
	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int BIT_TEN   = 7;
	localparam int BIT_SWAI  = 6;
	localparam int BIT_SFRZ  = 5;
	localparam int BIT_FFCA  = 4;
	localparam int BIT_TOF   = 7;
	localparam int BIT_ACCUM_OVERFLOW_FLAG = 1;
	localparam int BIT_ACCUM_INPUT_FLAG  = 0;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] RST_16    = 16'h0000;
	localparam logic [7:0]  RST_8     = 8'h00;
	localparam logic [5:0]  ACC_DIV   = 6'h3F;
	localparam logic [31:0] RD_UNMAP  = 32'h0000_0000;

	typedef struct packed {
		logic       run;
		logic       acc_run;
		logic       ffca;
	} tcc_ctl_s;
endpackage

//--- src/tcc_top.sv
// tcc_top: control part of an eight-channel 16-bit capture/compare timer.
// assumes synchronous pin inputs, a wait/freeze status from the cpu and a
// one-cycle-answer avalon-mm master with 32-bit words.
`timescale 1ns/1ps

// Overview of operation
// - counter writes only taken in test mode
// - first count after counter write may vary
// - enable bit 7 halts timer, not the compare/force/override pin actions
// - no divide-by-64 clock when timer inactive
// - stop-in-wait halts timer and accumulator
// - stop-in-freeze halts counter only
// - fast clear: capture channel read or compare channel write clears flag
// - fast clear: counter access clears overflow
// - fast clear: accumulator access clears its flags
// - toggle pin on overflow in compare mode
// - override beats toggle beats forced compare
// - nonzero action bits make pin output in compare mode
// - compare action: none, toggle, clear, set
// - edge bits select capture edge
// - enable bits gate channel flags to interrupt
// - 16-bit up counter on prescaled tick
// - overflow flag set on wrap to zero
// - write one clears flag, zero keeps
module tcc_top #(
	parameter int CHANNELS = 8
) (
	input  wire logic        sys_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        test_mode_in,
	input  wire logic        cpu_wait_in,
	input  wire logic        cpu_freeze_in,
	input  wire logic        prescale_tick_in,
	input  wire logic [7:0]  capture_pin_in,
	input  wire logic [7:0]  compare_match_in,
	input  wire logic        override_event_in,
	input  wire logic        accum_edge_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe_out,
	output logic      [7:0]  capture_event_out,
	output logic             accum_clk64_out,
	output logic             accum_run_out,
	output logic             irq_out
);
	// the register layout packs exactly eight channels into each register
	if (CHANNELS != 8) begin : g_bad_channels
		$error("tcc_top supports exactly 8 channels");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  scr1_q, tov_q, ien_q, ios_q, omask_q, odata_q, cflag_q;
	logic [15:0] act_q, edge_q, cnt_q, acc_q;
	logic        tof_q, accum_overflow_flag_q, accum_input_flag_q, ack_q;
	logic [5:0]  div_q;
	logic [7:0]  pin_q, cap_q, prev_q;
	logic        clk64_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire req      = (avs_read_in | avs_write_in) & ~ack_q;
	wire wr       = avs_write_in & req;
	wire rd       = avs_read_in & req;
	wire hit_cnt  = avs_address_in == tcc_pkg::OFS_CNT;
	wire hit_acc  = avs_address_in == tcc_pkg::OFS_ACC;
	wire hit_ch   = avs_address_in >= tcc_pkg::OFS_CH_BASE &&
		avs_address_in <= tcc_pkg::OFS_CH_LAST;
	wire [2:0] ch = 3'(avs_address_in[4:2]);
	wire [7:0] ch_oh = hit_ch ? (8'h01 << ch) : 8'h00;
	wire [7:0] wd8 = avs_writedata_in[7:0];

	tcc_pkg::tcc_ctl_s ctl;
	// counter, divider, capture, compare flags and accumulator off when disabled or stopped in wait
	assign ctl.run = scr1_q[tcc_pkg::BIT_TEN] &
		~(scr1_q[tcc_pkg::BIT_SWAI] & cpu_wait_in);
	// freeze stops only the counter, accumulator keeps going
	assign ctl.acc_run = ctl.run;
	assign ctl.ffca = scr1_q[tcc_pkg::BIT_FFCA];
	wire cnt_tick = ctl.run & prescale_tick_in &
		~(scr1_q[tcc_pkg::BIT_SFRZ] & cpu_freeze_in);
	wire cnt_wr   = wr & hit_cnt & test_mode_in;
	wire wrap     = cnt_tick & (cnt_q == tcc_pkg::CNT_MAX);

	// fast clear sources
	wire [7:0] fc_ch = ctl.ffca ? (ch_oh & ((~ios_q & {8{rd}}) |
		(ios_q & {8{wr}}))) : 8'h00;
	wire fc_cnt = ctl.ffca & req & hit_cnt;
	wire fc_acc = ctl.ffca & req & hit_acc;
	wire [7:0] w1c_ch = (wr && avs_address_in == tcc_pkg::OFS_CFLAG) ?
		wd8 : 8'h00;
	wire w1c_tof = wr && avs_address_in == tcc_pkg::OFS_OFLAG &&
		wd8[tcc_pkg::BIT_TOF];
	wire [7:0] force_v = (wr && avs_address_in == tcc_pkg::OFS_FORCE) ?
		wd8 : 8'h00;

	// ----------------------------------------------------------------
	// per-channel pin action and capture
	// ----------------------------------------------------------------
	logic [7:0] pin_d, cap_d, oe_d;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_ch
			wire om = act_q[2*g+1];
			wire ol = act_q[2*g];
			wire eb = edge_q[2*g+1];
			wire ea = edge_q[2*g];
			wire ovr = override_event_in & omask_q[g] & ios_q[g];
			wire tog = wrap & tov_q[g] & ios_q[g];
			wire cmp = ios_q[g] & (compare_match_in[g] | force_v[g]);
			logic act_v;
			always_comb begin
				case ({om, ol})
				2'b01:   act_v = ~pin_q[g];
				2'b10:   act_v = 1'b0;
				2'b11:   act_v = 1'b1;
				default: act_v = pin_q[g];
				endcase
			end
			// override first, then overflow toggle, then compare/force
			assign pin_d[g] = ovr ? odata_q[g] :
				tog ? ~pin_q[g] : cmp ? act_v : pin_q[g];
			assign oe_d[g] = ios_q[g] & ((om | ol) | omask_q[g]);
			wire rise = capture_pin_in[g] & ~prev_q[g];
			wire fall = ~capture_pin_in[g] & prev_q[g];
			assign cap_d[g] = ctl.run & ~ios_q[g] &
				((ea & rise) | (eb & fall));
		end
	endgenerate

	wire [7:0] set_ch = cap_d | (ios_q & compare_match_in & {8{ctl.run}});

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] rdata_d;
	always_comb begin
		case (avs_address_in)
		tcc_pkg::OFS_CNT:      rdata_d = {16'h0000, cnt_q};
		tcc_pkg::OFS_SCR1:     rdata_d = {24'h00_0000, scr1_q};
		tcc_pkg::OFS_TOV:      rdata_d = {24'h00_0000, tov_q};
		tcc_pkg::OFS_CFLAG:    rdata_d = {24'h00_0000, cflag_q};
		tcc_pkg::OFS_OFLAG:    rdata_d = {24'h00_0000, tof_q, 7'h00};
		tcc_pkg::OFS_ACT:      rdata_d = {16'h0000, act_q};
		tcc_pkg::OFS_EDGE:     rdata_d = {16'h0000, edge_q};
		tcc_pkg::OFS_IEN:      rdata_d = {24'h00_0000, ien_q};
		tcc_pkg::OFS_IOS:      rdata_d = {24'h00_0000, ios_q};
		tcc_pkg::OFS_OVR_MASK: rdata_d = {24'h00_0000, omask_q};
		tcc_pkg::OFS_OVR_DATA: rdata_d = {24'h00_0000, odata_q};
		tcc_pkg::OFS_ACC:      rdata_d = {16'h0000, acc_q};
		tcc_pkg::OFS_AFLAG:    rdata_d = {30'h0000_0000, accum_overflow_flag_q, accum_input_flag_q};
		default:               rdata_d = tcc_pkg::RD_UNMAP;
		endcase
	end

	// ----------------------------------------------------------------
	// bus slave: one wait state, answer on the second edge
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ack_q               <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= tcc_pkg::RD_UNMAP;
		end else begin
			ack_q               <= req;
			// kept as its own flop so the pin needs no inverter after it
			avs_waitrequest_out <= ~req;
			avs_readdata_out    <= rd ? rdata_d : avs_readdata_out;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			scr1_q  <= tcc_pkg::RST_8;
			tov_q   <= tcc_pkg::RST_8;
			ien_q   <= tcc_pkg::RST_8;
			ios_q   <= tcc_pkg::RST_8;
			omask_q <= tcc_pkg::RST_8;
			odata_q <= tcc_pkg::RST_8;
			act_q   <= tcc_pkg::RST_16;
			edge_q  <= tcc_pkg::RST_16;
		end else if (wr) begin
			if (avs_address_in == tcc_pkg::OFS_SCR1)     scr1_q  <= wd8;
			if (avs_address_in == tcc_pkg::OFS_TOV)      tov_q   <= wd8;
			if (avs_address_in == tcc_pkg::OFS_IEN)      ien_q   <= wd8;
			if (avs_address_in == tcc_pkg::OFS_IOS)      ios_q   <= wd8;
			if (avs_address_in == tcc_pkg::OFS_OVR_MASK) omask_q <= wd8;
			if (avs_address_in == tcc_pkg::OFS_OVR_DATA) odata_q <= wd8;
			if (avs_address_in == tcc_pkg::OFS_ACT)
				act_q <= avs_writedata_in[15:0];
			if (avs_address_in == tcc_pkg::OFS_EDGE)
				edge_q <= avs_writedata_in[15:0];
		end
	end

	// ----------------------------------------------------------------
	// counter, flags, divide-by-64, accumulator
	// ----------------------------------------------------------------
	// a test-mode write is not aligned to the prescale tick, so the
	// first period after it can be short
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cnt_q   <= tcc_pkg::RST_16;
			tof_q   <= 1'b0;
			cflag_q <= tcc_pkg::RST_8;
			div_q   <= 6'h00;
			clk64_q <= 1'b0;
			acc_q   <= tcc_pkg::RST_16;
			accum_overflow_flag_q <= 1'b0;
			accum_input_flag_q  <= 1'b0;
		end else begin
			if (cnt_wr)
				cnt_q <= avs_writedata_in[15:0];
			else if (cnt_tick)
				cnt_q <= cnt_q + 16'h0001;
			// hardware set wins over any clear in the same cycle
			tof_q   <= wrap | (tof_q & ~w1c_tof & ~fc_cnt);
			cflag_q <= set_ch | (cflag_q & ~w1c_ch & ~fc_ch);
			div_q   <= ctl.run ? div_q + 6'h01 : 6'h00;
			clk64_q <= ctl.run & (div_q == tcc_pkg::ACC_DIV);
			if (ctl.acc_run & accum_edge_in)
				acc_q <= acc_q + 16'h0001;
			accum_input_flag_q  <= (ctl.acc_run & accum_edge_in) |
				(accum_input_flag_q & ~fc_acc);
			accum_overflow_flag_q <= (ctl.acc_run & accum_edge_in &
				acc_q == tcc_pkg::CNT_MAX) | (accum_overflow_flag_q & ~fc_acc);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pin_q             <= tcc_pkg::RST_8;
			pin_oe_out        <= tcc_pkg::RST_8;
			prev_q            <= capture_pin_in; // no false edge after reset
			cap_q             <= tcc_pkg::RST_8;
			accum_run_out     <= 1'b0;
			irq_out           <= 1'b0;
		end else begin
			pin_q             <= pin_d;
			pin_oe_out        <= oe_d;
			prev_q            <= capture_pin_in;
			cap_q             <= cap_d;
			accum_run_out     <= ctl.acc_run;
			irq_out           <= |(cflag_q & ien_q & {8{~cpu_wait_in |
				~scr1_q[tcc_pkg::BIT_SWAI]}});
		end
	end
	assign pin_out           = pin_q;
	assign capture_event_out = cap_q;
	assign accum_clk64_out   = clk64_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_CNT_NOWRITE: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(wr && hit_cnt && !test_mode_in && !cnt_tick) |=>
		cnt_q == $past(cnt_q)) else $error("counter written outside test");
	AST_TEN_HALT: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(!scr1_q[tcc_pkg::BIT_TEN] && !cnt_wr) |=> $stable(cnt_q))
		else $error("counter moved while disabled");
	AST_NO_CLK64: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		!ctl.run |=> !accum_clk64_out) else $error("clk64 while off");
	AST_WAIT_STOP: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(scr1_q[tcc_pkg::BIT_SWAI] && cpu_wait_in) |=> !accum_run_out)
		else $error("accumulator ran in wait");
	AST_FRZ_ACC: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(scr1_q[tcc_pkg::BIT_TEN] && !cpu_wait_in) |=> accum_run_out)
		else $error("accumulator stopped by freeze");
	AST_TOF_SET: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		wrap |=> tof_q && ($past(cnt_wr) || cnt_q == 16'h0000))
		else $error("no overflow flag");
	AST_FC_CNT: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(fc_cnt && !wrap) |=> !tof_q) else $error("fast clear missed");
	AST_W1C: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(w1c_ch[0] && !set_ch[0]) |=> !cflag_q[0]) else $error("w1c missed");
	AST_IRQ: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(ien_q == 8'h00) |=> !irq_out) else $error("irq while masked");
	AST_OE: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(ios_q[0] && (act_q[1] | act_q[0])) |=> pin_oe_out[0])
		else $error("pin not driven");

	// ----------------------------------------------------------------
	// checks: counter gating and stepping, clk64 pulse, reset values
	// ----------------------------------------------------------------
	AST_FRZ_CNT: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(scr1_q[tcc_pkg::BIT_SFRZ] && cpu_freeze_in && !cnt_wr) |=>
		$stable(cnt_q)) else $error("counter ran in freeze");

	AST_WAIT_CNT: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(scr1_q[tcc_pkg::BIT_SWAI] && cpu_wait_in && !cnt_wr) |=>
		$stable(cnt_q)) else $error("counter ran in wait");

	AST_CNT_INC: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(cnt_tick && !cnt_wr) |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not step");

	AST_CLK64_GAP: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		accum_clk64_out |=> !accum_clk64_out)
		else $error("clk64 pulse too long");

	AST_RST_ZERO: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		$past(sys_rst_in) |-> (scr1_q == 8'h00 && act_q == 16'h0000 &&
		edge_q == 16'h0000)) else $error("control not zero after reset");

	// ----------------------------------------------------------------
	// checks: flags and interrupt
	// ----------------------------------------------------------------
	AST_FC_CH: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(fc_ch[0] && !set_ch[0]) |=> !cflag_q[0])
		else $error("channel fast clear missed");

	AST_FC_ACC: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(fc_acc && !(ctl.acc_run && accum_edge_in)) |=>
		(!accum_input_flag_q && !accum_overflow_flag_q)) else $error("accumulator flags kept");

	AST_W1C_TOF: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(w1c_tof && !wrap) |=> !tof_q) else $error("overflow w1c missed");

	AST_W0_KEEP: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(wr && avs_address_in == tcc_pkg::OFS_OFLAG && tof_q && !fc_cnt &&
		!wd8[tcc_pkg::BIT_TOF]) |=> tof_q) else $error("zero write cleared");

	AST_IRQ_ON: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(cflag_q[0] && ien_q[0] && !cpu_wait_in) |=> irq_out)
		else $error("enabled flag gave no irq");

	// ----------------------------------------------------------------
	// checks: pin actions and capture
	// ----------------------------------------------------------------
	AST_ACT_SET: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(ios_q[0] && act_q[1:0] == 2'b11 && compare_match_in[0] &&
		!tov_q[0] && !omask_q[0]) |=> pin_out[0])
		else $error("set action missed");

	AST_TOG: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(wrap && tov_q[1] && ios_q[1] && !override_event_in) |=>
		pin_out[1] != $past(pin_out[1])) else $error("no overflow toggle");

	AST_OVR: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(override_event_in && omask_q[1] && ios_q[1]) |=>
		pin_out[1] == $past(odata_q[1])) else $error("override lost");

	AST_CAP_RISE: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(ctl.run && !ios_q[3] && edge_q[6] && capture_pin_in[3] &&
		!prev_q[3]) |=> capture_event_out[3]) else $error("rise missed");

	AST_CAP_OFF: assert property (@(posedge sys_clk_in)
		disable iff (sys_rst_in)
		(edge_q[7:6] == 2'b00) |=> !capture_event_out[3])
		else $error("capture while disabled");
endmodule

//--- verification/tb_tcc_top.sv
// tb_tcc_top: self-checking bench for the capture/compare control block.
// assumes tcc_top answers each avalon-mm request after one wait cycle.
`timescale 1ns/1ps
module tb_tcc_top;
	logic        sys_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [7:0]  adr        = 8'h00;
	logic        rd         = 1'b0;
	logic        wr         = 1'b0;
	logic [31:0] wdat       = 32'h0000_0000;
	logic        tmode      = 1'b0;
	logic        cwait      = 1'b0;
	logic        cfrz       = 1'b0;
	logic        tick       = 1'b0;
	logic [7:0]  cap        = 8'h00;
	logic [7:0]  match      = 8'h00;
	logic        ovr        = 1'b0;
	logic        aedge      = 1'b0;
	logic [31:0] rdat;
	logic        wreq;
	logic [7:0]  pin;
	logic [7:0]  oe;
	logic [7:0]  capev;
	logic        c64;
	logic        arun;
	logic        irq;
	logic [31:0] v;
	int          h;
	int          miscompares = 0;
	int          tests_run   = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	tcc_top tcc_top_inst (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdat), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq), .test_mode_in(tmode),
		.cpu_wait_in(cwait), .cpu_freeze_in(cfrz), .prescale_tick_in(tick),
		.capture_pin_in(cap), .compare_match_in(match),
		.override_event_in(ovr), .accum_edge_in(aedge), .pin_out(pin),
		.pin_oe_out(oe), .capture_event_out(capev), .accum_clk64_out(c64),
		.accum_run_out(arun), .irq_out(irq)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("miscompares %0d of %0d checks", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t output %b expected %b", $time, g, e);
		end
	endtask
	// request held until waitrequest is seen low, data taken at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk_in);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= ~w;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk_in);
			if (wreq === 1'b0) break;
		end
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk32(v & m, e);
	endtask
	task automatic strobe(input logic t, input logic o, input logic [7:0] m,
		input logic a);
		@(posedge sys_clk_in);
		tick <= t;
		ovr <= o;
		match <= m;
		aedge <= a;
		@(posedge sys_clk_in);
		tick <= 1'b0;
		ovr <= 1'b0;
		match <= 8'h00;
		aedge <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
	endtask
	// counts pulses of one capture event bit, or of the /64 clock (s = 8)
	task automatic watch(input int n, input int s);
		h = 0;
		repeat (n) begin
			@(posedge sys_clk_in);
			if (s == 8) h += (c64 === 1'b1);
			else h += (capev[s] === 1'b1);
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] ofs [6];
		ofs = '{tcc_pkg::OFS_SCR1, tcc_pkg::OFS_TOV, tcc_pkg::OFS_ACT,
			tcc_pkg::OFS_EDGE, tcc_pkg::OFS_IEN, tcc_pkg::OFS_CNT};
		foreach (ofs[i]) rchk(ofs[i], 32'hFFFF_FFFF, 32'h0000_0000);
		chk32({24'h00_0000, oe}, 32'h0000_0000);
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		rchk(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask
	task automatic t_counter;
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_1234);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_0000);
		tmode <= 1'b1;
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_1234);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_1234);
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_1234);
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_0080);
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_1235);
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_FFFF);
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_0000);
		rchk(tcc_pkg::OFS_OFLAG, 32'h0000_0080, 32'h0000_0080);
		bus(1'b1, tcc_pkg::OFS_OFLAG, 32'h0000_0000);
		rchk(tcc_pkg::OFS_OFLAG, 32'h0000_0080, 32'h0000_0080);
		bus(1'b1, tcc_pkg::OFS_OFLAG, 32'h0000_0080);
		rchk(tcc_pkg::OFS_OFLAG, 32'h0000_0080, 32'h0000_0000);
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_FFFF);
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_0090);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_0000);
		rchk(tcc_pkg::OFS_OFLAG, 32'h0000_0080, 32'h0000_0000);
	endtask
	task automatic t_modes;
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_0100);
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_00A0);
		cfrz <= 1'b1;
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_0100);
		chk_bit(arun, 1'b1);
		cfrz <= 1'b0;
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_00C0);
		cwait <= 1'b1;
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_0100);
		chk_bit(arun, 1'b0);
		cwait <= 1'b0;
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		rchk(tcc_pkg::OFS_CNT, 32'h0000_FFFF, 32'h0000_0101);
		watch(150, 8);
		chk_bit(h > 0, 1'b1);
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_0000);
		repeat (3) @(posedge sys_clk_in);
		watch(150, 8);
		chk32(32'(h), 32'h0000_0000);
	endtask
	task automatic t_irq;
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_0080);
		bus(1'b1, tcc_pkg::OFS_IOS, 32'h0000_0001);
		bus(1'b1, tcc_pkg::OFS_IEN, 32'h0000_0001);
		strobe(1'b0, 1'b0, 8'h01, 1'b1);
		rchk(tcc_pkg::OFS_CFLAG, 32'h0000_0001, 32'h0000_0001);
		chk_bit(irq, 1'b1);
		bus(1'b1, tcc_pkg::OFS_IEN, 32'h0000_0000);
		repeat (2) @(posedge sys_clk_in);
		chk_bit(irq, 1'b0);
		bus(1'b1, tcc_pkg::OFS_IEN, 32'h0000_0001);
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_0090);
		bus(1'b1, tcc_pkg::OFS_CH_BASE, 32'h0000_0010);
		rchk(tcc_pkg::OFS_CFLAG, 32'h0000_0001, 32'h0000_0000);
		chk_bit(irq, 1'b0);
		rchk(tcc_pkg::OFS_AFLAG, 32'h0000_0001, 32'h0000_0001);
		bus(1'b0, tcc_pkg::OFS_ACC, 32'h0000_0000);
		rchk(tcc_pkg::OFS_AFLAG, 32'h0000_0003, 32'h0000_0000);
		bus(1'b1, tcc_pkg::OFS_SCR1, 32'h0000_0080);
	endtask
	task automatic t_action;
		logic [1:0] code [4];
		logic       exp [4];
		code = '{2'b11, 2'b10, 2'b01, 2'b01};
		exp = '{1'b1, 1'b0, 1'b1, 1'b0};
		bus(1'b1, tcc_pkg::OFS_IOS, 32'h0000_00FF);
		foreach (code[i]) begin
			bus(1'b1, tcc_pkg::OFS_ACT, {30'h0000_0000, code[i]});
			strobe(1'b0, 1'b0, 8'h01, 1'b0);
			chk_bit(pin[0], exp[i]);
			chk_bit(oe[0], 1'b1);
		end
		bus(1'b1, tcc_pkg::OFS_ACT, 32'h0000_0003);
		bus(1'b1, tcc_pkg::OFS_FORCE, 32'h0000_0001);
		chk_bit(pin[0], 1'b1);
		bus(1'b1, tcc_pkg::OFS_ACT, 32'h0000_0008);
		// the enable flop takes the new action bits one edge after the write
		@(posedge sys_clk_in);
		chk_bit(oe[0], 1'b0);
		bus(1'b1, tcc_pkg::OFS_TOV, 32'h0000_0002);
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_FFFF);
		strobe(1'b1, 1'b0, 8'h00, 1'b0);
		chk_bit(pin[1], 1'b1);
		bus(1'b1, tcc_pkg::OFS_OVR_MASK, 32'h0000_0002);
		bus(1'b1, tcc_pkg::OFS_OVR_DATA, 32'h0000_0002);
		bus(1'b1, tcc_pkg::OFS_CNT, 32'h0000_FFFF);
		strobe(1'b1, 1'b1, 8'h00, 1'b0);
		chk_bit(pin[1], 1'b1);
		bus(1'b1, tcc_pkg::OFS_OVR_MASK, 32'h0000_0000);
		strobe(1'b0, 1'b0, 8'h02, 1'b0);
		chk_bit(pin[1], 1'b0);
		chk_bit(oe[7], 1'b0);
		strobe(1'b0, 1'b0, 8'h00, 1'b1);
		rchk(tcc_pkg::OFS_ACC, 32'h0000_FFFF, 32'h0000_0002);
	endtask
	task automatic t_edge;
		bus(1'b1, tcc_pkg::OFS_IOS, 32'h0000_0000);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, tcc_pkg::OFS_EDGE, 32'(c << 6));
			cap[3] <= 1'b1;
			watch(4, 3);
			chk32(32'(h), 32'(c % 2));
			cap[3] <= 1'b0;
			watch(4, 3);
			chk32(32'(h), 32'(c / 2));
		end
	endtask

	initial begin
		repeat (16) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_counter();
		t_modes();
		t_irq();
		t_action();
		t_edge();
		wrap_up();
	end
endmodule
